// File: scss_pkg.sv
// Constants and types for the system clock source select block
package scss_pkg;

    typedef enum logic [2:0] {
        SRC_HFINT_32M = 3'h0,
        SRC_RSVD_1    = 3'h1,
        SRC_EXT_PLL   = 3'h2,
        SRC_RSVD_3    = 3'h3,
        SRC_SECONDARY = 3'h4,
        SRC_LFINT     = 3'h5,
        SRC_HFINT_1M  = 3'h6,
        SRC_EXT       = 3'h7
    } scss_src_t;

    typedef enum logic [2:0] {
        EXT_OFF         = 3'h0,
        EXT_CLK_LOW_PWR = 3'h1,
        EXT_CLK_HI_PWR  = 3'h2,
        EXT_RSVD_3      = 3'h3,
        EXT_LOW_GAIN    = 3'h4,
        EXT_MED_GAIN    = 3'h5,
        EXT_HIGH_GAIN   = 3'h6,
        EXT_RSVD_7      = 3'h7
    } scss_ext_mode_t;

    localparam logic [1:0]  GAIN_NONE      = 2'h0;
    localparam logic [1:0]  GAIN_LOW       = 2'h1;
    localparam logic [1:0]  GAIN_MED       = 2'h2;
    localparam logic [1:0]  GAIN_HIGH      = 2'h3;

    localparam logic [3:0]  DIV_1_1        = 4'h0;
    localparam logic [3:0]  DIV_MAX_CODE   = 4'h9;
    localparam logic [2:0]  FRQ_1MHZ       = 3'h0;
    localparam logic [2:0]  FRQ_4MHZ       = 3'h2;
    localparam logic [2:0]  FRQ_32MHZ      = 3'h5;

    localparam int          STARTUP_PERIODS = 1024;
    localparam logic [10:0] STARTUP_COUNT   = 11'(STARTUP_PERIODS);
    localparam int          LFINT_FREQ_KHZ  = 31;
    localparam int          INSTR_DIV       = 4;
    localparam logic [1:0]  INSTR_HALF_LAST = 2'(INSTR_DIV / 2 - 1);

endpackage : scss_pkg

// File: scss_props.sv
// Checker for the clock source select block
`timescale 1ns/1ps
module scss_props
    import scss_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    input wire logic [2:0] external_mode_select_i,
    input wire logic       clock_out_enable_n_i,
    input wire logic       new_request_valid_i,
    input wire logic [2:0] new_source_request_i,
    input wire logic       clock_in_running_i,
    input wire logic [2:0] current_source_o,
    input wire logic [3:0] current_divider_o,
    input wire logic [1:0] amp_gain_o,
    input wire logic       amp_enable_o,
    input wire logic       clock_in_direct_o,
    input wire logic       internal_low_freq_osc_en_o,
    input wire logic       converter_rc_osc_en_o,
    input wire logic       external_osc_ready_o,
    input wire logic       switch_pending_o,
    input wire logic       sys_clk_en_o,
    input wire logic       instruction_clock_out_o,
    input wire logic       clock_out_pin_oe_o,
    input wire logic       halted_o
);
    logic [1:0] live_q;
    logic [2:0] mode_q;
    logic       enn_q;
    logic       clk_mode;
    logic       ext_sel;
    logic [1:0] gain_exp;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            live_q <= 2'h0;
        end else if (live_q != 2'h3) begin
            live_q <= live_q + 2'h1;
        end
    end

    // Straps count only on the first edge after release
    always_ff @(posedge clk_i) begin
        if (rst_b_i && live_q == 2'h0) begin
            mode_q <= external_mode_select_i;
            enn_q  <= clock_out_enable_n_i;
        end
    end

    assign clk_mode = (mode_q == 3'h1) || (mode_q == 3'h2);
    assign ext_sel  = (live_q == 2'h3) && (current_source_o == 3'h7);
    assign gain_exp = (mode_q == 3'h4) ? GAIN_LOW : (mode_q == 3'h5) ? GAIN_MED :
                      (mode_q == 3'h6) ? GAIN_HIGH : GAIN_NONE;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_take;
        live_q == 2'h3 && new_request_valid_i && !switch_pending_o
            && new_source_request_i != 3'h1 && new_source_request_i != 3'h3
            && new_source_request_i != current_source_o;
    endsequence
    sequence s_out_period;
        instruction_clock_out_o ##1 !instruction_clock_out_o [*2] ##1 instruction_clock_out_o;
    endsequence

    a_req_pending: assert property (s_take |=> switch_pending_o)
        else $error("legal request did not raise pending");
    a_sel_hold: assert property (live_q == 2'h3 &&
        ($changed(current_source_o) || $changed(current_divider_o)) |-> $fell(switch_pending_o))
        else $error("selection changed outside a switch completion");
    a_gain_map: assert property (ext_sel |-> amp_gain_o == gain_exp)
        else $error("amplifier gain does not match mode");
    a_ext_direct: assert property (ext_sel && clk_mode |-> clock_in_direct_o && !amp_enable_o)
        else $error("clock mode not taken directly");
    a_ready_bypass: assert property (ext_sel && clk_mode |-> external_osc_ready_o)
        else $error("start-up delay not bypassed");
    a_oe_strap: assert property (live_q == 2'h3 |-> clock_out_pin_oe_o == !enn_q)
        else $error("clock out pin enable wrong");
    a_instruction_clock_out_div: assert property (live_q == 2'h3 && !enn_q && sys_clk_en_o &&
        $rose(instruction_clock_out_o) |=> s_out_period)
        else $error("instruction clock not divided by four");
    a_halt_stop: assert property (ext_sel && clk_mode && !clock_in_running_i
        |-> ##[1:3] (halted_o && !sys_clk_en_o))
        else $error("no halt when clock input stopped");
    a_halt_resume: assert property (halted_o && clock_in_running_i |-> ##[1:3] !halted_o)
        else $error("no resume after clock restart");
    a_rc_running: assert property (live_q == 2'h3 |-> converter_rc_osc_en_o)
        else $error("converter oscillator not running");
endmodule : scss_props

bind scss_top scss_props i_scss_props (.*);

// File: scss_startup_timer.sv
// Start-up timer counting input periods before external ready
`timescale 1ns/1ps
module scss_startup_timer
    import scss_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic restart_i,
    input  wire logic bypass_i,
    input  wire logic osc_edge_i,
    output logic      ready_o
);
    logic [10:0] cnt_q;
    logic [10:0] cnt_d;
    logic        rdy_q;
    logic        rdy_d;

    always_comb begin
        cnt_d = cnt_q;
        rdy_d = rdy_q;
        if (restart_i) begin
            cnt_d = '0;
            rdy_d = bypass_i;
        end else if (bypass_i) begin
            rdy_d = 1'b1;
        end else if (!rdy_q && osc_edge_i) begin
            cnt_d = cnt_q + 11'h001;
            if (cnt_d == STARTUP_COUNT) begin
                rdy_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    assign ready_o = rdy_q;

endmodule : scss_startup_timer

// File: scss_top.sv
// Clock source selection, divider, gain and clock-out control
`timescale 1ns/1ps
module scss_top
    import scss_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [2:0] reset_source_select_i,
    input  wire logic [2:0] external_mode_select_i,
    input  wire logic       clock_out_enable_n_i,
    input  wire logic       new_request_valid_i,
    input  wire logic [2:0] new_source_request_i,
    input  wire logic [3:0] new_divider_request_i,
    input  wire logic       freq_write_i,
    input  wire logic [2:0] internal_freq_select_i,
    input  wire logic       wake_i,
    input  wire logic       clock_in_pin_i,
    input  wire logic       clock_in_running_i,
    input  wire logic       secondary_osc_ready_i,
    input  wire logic       internal_high_freq_osc_ready_i,
    input  wire logic       internal_low_freq_osc_ready_i,
    input  wire logic       pll_locked_i,
    output logic [2:0]      current_source_o,
    output logic [3:0]      current_divider_o,
    output logic [2:0]      internal_freq_select_o,
    output logic [1:0]      amp_gain_o,
    output logic            amp_enable_o,
    output logic            clock_in_direct_o,
    output logic            pll_enable_o,
    output logic            internal_high_freq_osc_en_o,
    output logic            internal_low_freq_osc_en_o,
    output logic            secondary_osc_en_o,
    output logic            converter_rc_osc_en_o,
    output logic            external_osc_ready_o,
    output logic            switch_pending_o,
    output logic            sys_clk_en_o,
    output logic            instruction_clock_out_o,
    output logic            clock_out_pin_oe_o,
    output logic            halted_o
);

    typedef enum logic [1:0] {
        SW_BOOT,
        SW_IDLE,
        SW_WAIT
    } scss_sw_state_t;

    function automatic logic is_external(input logic [2:0] src);
        is_external = (src == SRC_EXT) || (src == SRC_EXT_PLL);
    endfunction : is_external

    function automatic logic is_ext_clock(input logic [2:0] mode);
        is_ext_clock = (mode == EXT_CLK_LOW_PWR) || (mode == EXT_CLK_HI_PWR);
    endfunction : is_ext_clock

    function automatic logic src_legal(input logic [2:0] src);
        src_legal = (src != SRC_RSVD_1) && (src != SRC_RSVD_3);
    endfunction : src_legal

    scss_sw_state_t state_q;
    scss_sw_state_t state_d;
    logic [2:0]     cur_src_q;
    logic [2:0]     cur_src_d;
    logic [3:0]     cur_div_q;
    logic [3:0]     cur_div_d;
    logic [2:0]     frq_q;
    logic [2:0]     frq_d;
    logic [2:0]     ext_mode_q;
    logic [2:0]     ext_mode_d;
    logic           instruction_clock_out_n_q;
    logic           instruction_clock_out_n_d;
    logic [2:0]     new_src_q;
    logic [2:0]     new_src_d;
    logic [3:0]     new_div_q;
    logic [3:0]     new_div_d;
    logic           pend_q;
    logic           pend_d;
    logic           new_ready;
    logic           ext_ready;
    logic           ost_restart;
    logic           ost_bypass;
    logic           pin_q;
    logic           pin_edge;

    // Defaults are captured on the first clocked cycle after release
    always_comb begin
        state_d    = state_q;
        cur_src_d  = cur_src_q;
        cur_div_d  = cur_div_q;
        frq_d      = frq_q;
        ext_mode_d = ext_mode_q;
        instruction_clock_out_n_d = instruction_clock_out_n_q;
        new_src_d  = new_src_q;
        new_div_d  = new_div_q;
        pend_d     = 1'b0;
        case (state_q)
            SW_BOOT: begin
                ext_mode_d = external_mode_select_i;
                instruction_clock_out_n_d = clock_out_enable_n_i;
                cur_div_d  = DIV_1_1;
                case (reset_source_select_i)
                    SRC_EXT: begin
                        cur_src_d = SRC_EXT;
                        frq_d     = FRQ_1MHZ;
                    end
                    SRC_HFINT_1M: begin
                        cur_src_d = SRC_HFINT_1M;
                        frq_d     = FRQ_1MHZ;
                    end
                    SRC_LFINT: begin
                        cur_src_d = SRC_LFINT;
                        frq_d     = FRQ_4MHZ;
                    end
                    SRC_SECONDARY: begin
                        cur_src_d = SRC_SECONDARY;
                        frq_d     = FRQ_1MHZ;
                    end
                    SRC_EXT_PLL: begin
                        cur_src_d = SRC_EXT_PLL;
                        frq_d     = FRQ_4MHZ;
                    end
                    default: begin
                        // Reserved codes and SRC_HFINT_32M fall back to the fast internal default
                        cur_src_d = SRC_HFINT_1M;
                        frq_d     = FRQ_32MHZ;
                    end
                endcase
                new_src_d = cur_src_d;
                new_div_d = DIV_1_1;
                state_d   = SW_IDLE;
            end
            SW_IDLE: begin
                if (new_request_valid_i && src_legal(new_source_request_i)) begin
                    new_src_d = new_source_request_i;
                    new_div_d = (new_divider_request_i > DIV_MAX_CODE) ?
                                DIV_MAX_CODE : new_divider_request_i;
                    pend_d    = 1'b1;
                    state_d   = SW_WAIT;
                end
            end
            SW_WAIT: begin
                pend_d = 1'b1;
                if (new_ready) begin
                    cur_src_d = new_src_q;
                    cur_div_d = new_div_q;
                    pend_d    = 1'b0;
                    state_d   = SW_IDLE;
                end
            end
            default: begin
                state_d = SW_BOOT;
            end
        endcase
        if (freq_write_i && state_q != SW_BOOT) begin
            frq_d = internal_freq_select_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_q    <= SW_BOOT;
            cur_src_q  <= SRC_HFINT_1M;
            cur_div_q  <= DIV_1_1;
            frq_q      <= FRQ_1MHZ;
            ext_mode_q <= EXT_OFF;
            instruction_clock_out_n_q <= 1'b1;
            new_src_q  <= SRC_HFINT_1M;
            new_div_q  <= DIV_1_1;
            pend_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            cur_src_q  <= cur_src_d;
            cur_div_q  <= cur_div_d;
            frq_q      <= frq_d;
            ext_mode_q <= ext_mode_d;
            instruction_clock_out_n_q <= instruction_clock_out_n_d;
            new_src_q  <= new_src_d;
            new_div_q  <= new_div_d;
            pend_q     <= pend_d;
        end
    end

    // Readiness of the requested source
    always_comb begin
        case (new_src_q)
            SRC_EXT:       new_ready = ext_ready;
            SRC_EXT_PLL:   new_ready = ext_ready && pll_locked_i;
            SRC_SECONDARY: new_ready = secondary_osc_ready_i;
            SRC_LFINT:     new_ready = internal_low_freq_osc_ready_i;
            SRC_HFINT_1M:  new_ready = internal_high_freq_osc_ready_i;
            default:       new_ready = 1'b0;
        endcase
    end

    // Input pin edges drive the start-up count
    logic pin_q_d;
    always_comb begin
        pin_q_d = clock_in_pin_i;
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_q_d;
        end
    end
    assign pin_edge    = clock_in_pin_i && !pin_q;
    assign ost_restart = (state_q == SW_BOOT) || wake_i;
    assign ost_bypass  = is_ext_clock(ext_mode_q);

    scss_startup_timer u_ost (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .restart_i  (ost_restart),
        .bypass_i   (ost_bypass),
        .osc_edge_i (pin_edge),
        .ready_o    (ext_ready)
    );

    // Outputs and instruction clock divider
    logic [1:0] gain_d;
    logic [1:0] gain_q;
    logic       ext_use;
    logic       outs_amp_d;
    logic       outs_direct_d;
    logic       outs_pll_d;
    logic [1:0] icnt_q;
    logic [1:0] icnt_d;
    logic       iclk_q;
    logic       iclk_d;
    logic       amp_q;
    logic       direct_q;
    logic       pll_q;
    logic       halt_q;
    logic       halt_d;
    logic       run_q;
    logic       run_d;
    logic       hf_en_q;
    logic       hf_en_d;
    logic       sec_en_q;
    logic       sec_en_d;
    logic       oe_q;
    logic       oe_d;
    logic       clko_q;
    logic       clko_d;
    logic       osc_on_q;

    always_comb begin
        ext_use       = is_external(cur_src_q) || is_external(new_src_q);
        gain_d        = GAIN_NONE;
        outs_amp_d    = 1'b0;
        outs_direct_d = 1'b0;
        case (ext_mode_q)
            EXT_LOW_GAIN:  gain_d = GAIN_LOW;
            EXT_MED_GAIN:  gain_d = GAIN_MED;
            EXT_HIGH_GAIN: gain_d = GAIN_HIGH;
            default:       gain_d = GAIN_NONE;
        endcase
        if (ext_use) begin
            outs_amp_d    = (gain_d != GAIN_NONE);
            outs_direct_d = is_ext_clock(ext_mode_q);
        end else begin
            gain_d = GAIN_NONE;
        end
        // Only the external path feeds the multiplier
        outs_pll_d = (cur_src_q == SRC_EXT_PLL) || (new_src_q == SRC_EXT_PLL);
        // Stalled external clock freezes the core, no state is touched
        halt_d = is_external(cur_src_q) && is_ext_clock(ext_mode_q)
                 && !clock_in_running_i;
        run_d  = (state_q != SW_BOOT) && !halt_d;
        icnt_d = icnt_q;
        iclk_d = iclk_q;
        if (run_d) begin
            if (icnt_q == INSTR_HALF_LAST) begin
                icnt_d = '0;
                iclk_d = !iclk_q;
            end else begin
                icnt_d = icnt_q + 2'h1;
            end
        end
        // Next-state decode keeps the enables in step with the selection
        hf_en_d  = (cur_src_d == SRC_HFINT_1M) || (new_src_d == SRC_HFINT_1M);
        sec_en_d = (cur_src_d == SRC_SECONDARY) || (new_src_d == SRC_SECONDARY);
        oe_d     = !instruction_clock_out_n_d;
        clko_d   = iclk_d && !instruction_clock_out_n_d;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            gain_q   <= GAIN_NONE;
            amp_q    <= 1'b0;
            direct_q <= 1'b0;
            pll_q    <= 1'b0;
            halt_q   <= 1'b0;
            run_q    <= 1'b0;
            icnt_q   <= '0;
            iclk_q   <= 1'b0;
            hf_en_q  <= 1'b0;
            sec_en_q <= 1'b0;
            oe_q     <= 1'b0;
            clko_q   <= 1'b0;
            osc_on_q <= 1'b0;
        end else begin
            gain_q   <= gain_d;
            amp_q    <= outs_amp_d;
            direct_q <= outs_direct_d;
            pll_q    <= outs_pll_d;
            halt_q   <= halt_d;
            run_q    <= run_d;
            icnt_q   <= icnt_d;
            iclk_q   <= iclk_d;
            hf_en_q  <= hf_en_d;
            sec_en_q <= sec_en_d;
            oe_q     <= oe_d;
            clko_q   <= clko_d;
            osc_on_q <= 1'b1;
        end
    end

    assign current_source_o            = cur_src_q;
    assign current_divider_o           = cur_div_q;
    assign internal_freq_select_o      = frq_q;
    assign amp_gain_o                  = gain_q;
    assign amp_enable_o                = amp_q;
    assign clock_in_direct_o           = direct_q;
    assign pll_enable_o                = pll_q;
    assign internal_high_freq_osc_en_o = hf_en_q;
    assign internal_low_freq_osc_en_o  = osc_on_q;
    assign secondary_osc_en_o          = sec_en_q;
    assign converter_rc_osc_en_o       = osc_on_q;
    assign external_osc_ready_o        = ext_ready;
    assign switch_pending_o            = pend_q;
    assign sys_clk_en_o                = run_q;
    assign instruction_clock_out_o     = clko_q;
    assign clock_out_pin_oe_o          = oe_q;
    assign halted_o                    = halt_q;

endmodule : scss_top

// File: tb_top.sv
// Self-checking bench for the clock source select block
`timescale 1ns/1ps
module tb_top
    import scss_pkg::*;
;
    logic       clk_i = 1'b0, rst_b_i = 1'b0, clock_out_enable_n_i = 1'b1, wake_i = 1'b0;
    logic       new_request_valid_i = 1'b0, freq_write_i = 1'b0, clock_in_pin_i = 1'b0;
    logic       clock_in_running_i = 1'b1, secondary_osc_ready_i = 1'b1, pll_locked_i = 1'b1;
    logic       internal_high_freq_osc_ready_i = 1'b1, internal_low_freq_osc_ready_i = 1'b1;
    logic [2:0] reset_source_select_i = 3'h6, external_mode_select_i = 3'h2;
    logic [2:0] new_source_request_i = 3'h6, internal_freq_select_i = 3'h0;
    logic [3:0] new_divider_request_i = 4'h0;
    logic [2:0] current_source_o, internal_freq_select_o;
    logic [3:0] current_divider_o;
    logic [1:0] amp_gain_o;
    logic       amp_enable_o, clock_in_direct_o, pll_enable_o, internal_high_freq_osc_en_o;
    logic       internal_low_freq_osc_en_o, secondary_osc_en_o, converter_rc_osc_en_o;
    logic       external_osc_ready_o, switch_pending_o, sys_clk_en_o, instruction_clock_out_o;
    logic       clock_out_pin_oe_o, halted_o, prev;
    int         error_cnt = 0, checked = 0, rises;
    logic [2:0] codes [8] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0, 3'h3, 3'h1};
    // Pin rates stay far below what each crystal gain is meant for
    logic [2:0] modes [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    logic [1:0] gains [5] = '{GAIN_NONE, GAIN_NONE, GAIN_LOW, GAIN_MED, GAIN_HIGH};

    scss_top i_scss_top (.*);

    always #4 clk_i = ~clk_i;

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Sample just after the edge so its updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    task automatic boot(input logic [2:0] rs, input logic [2:0] em, input logic en);
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        reset_source_select_i <= rs;
        external_mode_select_i <= em;
        clock_out_enable_n_i <= en;
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        cyc(4);
    endtask : boot

    task automatic req(input logic [2:0] s, input logic [3:0] d);
        @(posedge clk_i);
        new_request_valid_i <= 1'b1;
        new_source_request_i <= s;
        new_divider_request_i <= d;
        @(posedge clk_i);
        new_request_valid_i <= 1'b0;
        #1;
    endtask : req

    task automatic wait_idle();
        int n;
        n = 0;
        while (switch_pending_o !== 1'b0 && n < 100) begin
            cyc(1);
            n++;
        end
        if (switch_pending_o !== 1'b0) begin
            error_cnt++;
            test_done();
        end
        cyc(2);
    endtask : wait_idle

    // Whole pin periods only, so every call adds exactly n rising edges
    task automatic pins(input int n);
        repeat (n) begin
            @(posedge clk_i);
            clock_in_pin_i <= 1'b1;
            @(posedge clk_i);
            clock_in_pin_i <= 1'b0;
        end
        cyc(4);
    endtask : pins

    function automatic logic [2:0] def_src(input logic [2:0] rs);
        def_src = (rs inside {3'h7, 3'h5, 3'h4, 3'h2}) ? rs : SRC_HFINT_1M;
    endfunction : def_src

    function automatic logic [2:0] def_frq(input logic [2:0] rs);
        def_frq = (rs == 3'h6) ? FRQ_1MHZ : (rs inside {3'h5, 3'h2}) ? FRQ_4MHZ : FRQ_32MHZ;
    endfunction : def_frq

    initial begin
        foreach (codes[i]) begin
            boot(codes[i], 3'h2, 1'b0);
            chk(current_source_o, def_src(codes[i]));
            chk(current_divider_o, DIV_1_1);
            if (codes[i] != 3'h7 && codes[i] != 3'h4) chk(internal_freq_select_o, def_frq(codes[i]));
            chk(pll_enable_o, codes[i] == 3'h2);
            chk(clock_out_pin_oe_o, 1'b1);
            rises = 0;
            prev = instruction_clock_out_o;
            repeat (16) begin
                cyc(1);
                if (instruction_clock_out_o && !prev) rises++;
                prev = instruction_clock_out_o;
            end
            chk(4'(rises), 4'h4);
        end
        $display("reset defaults done");
        foreach (modes[i]) begin
            boot(3'h7, modes[i], 1'b1);
            chk(clock_out_pin_oe_o, 1'b0);
            chk(amp_gain_o, gains[i]);
            chk(amp_enable_o, modes[i] >= 3'h4);
            chk(internal_low_freq_osc_en_o, 1'b1);
            chk(converter_rc_osc_en_o, 1'b1);
            chk(instruction_clock_out_o, 1'b0);
            chk(clock_in_direct_o, modes[i] < 3'h4);
            chk(external_osc_ready_o, modes[i] < 3'h4);
            if (modes[i] >= 3'h4) begin
                repeat (2) begin
                    pins(1023);
                    chk(external_osc_ready_o, 1'b0);
                    pins(1);
                    chk(external_osc_ready_o, 1'b1);
                    @(posedge clk_i);
                    wake_i <= 1'b1;
                    @(posedge clk_i);
                    wake_i <= 1'b0;
                end
            end else begin
                @(posedge clk_i);
                clock_in_running_i <= 1'b0;
                cyc(5);
                chk(halted_o, 1'b1);
                chk(sys_clk_en_o, 1'b0);
                chk(current_source_o, SRC_EXT);
                @(posedge clk_i);
                clock_in_running_i <= 1'b1;
                cyc(5);
                chk(halted_o, 1'b0);
                chk(sys_clk_en_o, 1'b1);
            end
        end
        $display("external modes done");
        @(posedge clk_i);
        secondary_osc_ready_i <= 1'b0;
        pll_locked_i <= 1'b0;
        boot(3'h6, 3'h2, 1'b1);
        req(SRC_SECONDARY, 4'h3);
        chk(switch_pending_o, 1'b1);
        chk(secondary_osc_en_o, 1'b1);
        req(SRC_LFINT, 4'h1);
        cyc(6);
        chk(current_source_o, SRC_HFINT_1M);
        @(posedge clk_i);
        secondary_osc_ready_i <= 1'b1;
        wait_idle();
        chk(current_source_o, SRC_SECONDARY);
        chk(current_divider_o, 4'h3);
        req(SRC_LFINT, 4'hF);
        wait_idle();
        chk(current_source_o, SRC_LFINT);
        chk(current_divider_o, DIV_MAX_CODE);
        chk(secondary_osc_en_o, 1'b0);
        req(3'h3, 4'h0);
        chk(switch_pending_o, 1'b0);
        req(SRC_EXT_PLL, 4'h0);
        cyc(4);
        chk(current_source_o, SRC_LFINT);
        @(posedge clk_i);
        pll_locked_i <= 1'b1;
        wait_idle();
        chk(current_source_o, SRC_EXT_PLL);
        chk(pll_enable_o, 1'b1);
        req(SRC_HFINT_1M, 4'h0);
        wait_idle();
        chk(pll_enable_o, 1'b0);
        chk(internal_high_freq_osc_en_o, 1'b1);
        @(posedge clk_i);
        freq_write_i <= 1'b1;
        internal_freq_select_i <= FRQ_32MHZ;
        @(posedge clk_i);
        freq_write_i <= 1'b0;
        cyc(2);
        chk(internal_freq_select_o, FRQ_32MHZ);
        req(SRC_EXT, 4'h0);
        wait_idle();
        chk(current_source_o, SRC_EXT);
        chk(clock_in_direct_o, 1'b1);
        chk(internal_high_freq_osc_en_o, 1'b0);
        $display("clock switching done");
        test_done();
    end
endmodule : tb_top
